// [common/eqs_pkg.sv]
// Constants, record layout and state type shared by the error queue block.
package eqs_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam longint unsigned CLK_HZ           = 200_000_000;
   localparam longint unsigned VIEW_TIMEOUT_S   = 30;
   localparam longint unsigned TST_TIME_S       = 2;
   localparam longint unsigned VIEW_TIMEOUT_CYC = VIEW_TIMEOUT_S * CLK_HZ;
   localparam longint unsigned TST_CYC          = TST_TIME_S * CLK_HZ;
   localparam int unsigned     TMR_W            = 33;

   // ----------------------------------------------------------------
   // Queue geometry
   // ----------------------------------------------------------------
   localparam int unsigned     DEPTH     = 20;
   localparam int unsigned     PTR_W     = 5;
   localparam logic [4:0]      DEPTH_CNT = 5'h14;
   localparam logic [4:0]      PTR_LAST  = 5'h13;

   // ----------------------------------------------------------------
   // Record layout: signed code, message id, message length
   // ----------------------------------------------------------------
   localparam int unsigned     CODE_W       = 16;
   localparam int unsigned     ID_W         = 8;
   localparam int unsigned     LEN_W        = 7;
   localparam int unsigned     REC_W        = CODE_W + ID_W + LEN_W;
   localparam int unsigned     REC_CODE_LSB = ID_W + LEN_W;
   localparam int unsigned     REC_ID_LSB   = LEN_W;
   localparam int unsigned     REC_LEN_LSB  = 0;

   localparam logic [15:0]     CODE_NOERR  = 16'h0000;
   localparam logic [15:0]     CODE_OVF    = 16'hfea2;
   localparam logic [7:0]      MSG_NOERR   = 8'h00;
   localparam logic [7:0]      MSG_OVF     = 8'h01;
   localparam logic [6:0]      LEN_NOERR   = 7'h08;
   localparam logic [6:0]      LEN_OVF     = 7'h0e;
   localparam logic [6:0]      MSG_MAX_LEN = 7'h50;

   // ----------------------------------------------------------------
   // Indicators and self-test
   // ----------------------------------------------------------------
   localparam int unsigned     ANN_W       = 8;
   localparam logic            TST_PASS    = 1'b0;
   localparam logic            TST_FAIL    = 1'b1;

   typedef enum logic [0:0] {
      EQS_TST_IDLE = 1'b0,
      EQS_TST_RUN  = 1'b1
   } eqs_tst_t;

endpackage

// [dv/eqs_host_model.sv]
// Remote host model that sends one error query at a time and takes the answers.
module eqs_host_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic go,
   input  wire logic stall,
   input  wire logic pop_ready,
   output logic      pop_req,
   output logic      rd_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   // A query is held until the device takes it, so none is ever lost or doubled.
   always_ff @(posedge clk) begin
      if (rst) begin
         pop_req <= 1'b0;
      end else if (go && !pop_req) begin
         pop_req <= 1'b1;
      end else if (pop_req && pop_ready) begin
         pop_req <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      rd_ready <= !stall && !rst;
   end
endmodule

// [dv/eqs_properties.sv]
// Concurrent checks on the ports of the error queue top module.
module eqs_properties
   import eqs_pkg::*;
#(
   parameter longint unsigned TST_RUN_CYC = 20
) (
   input wire logic             REF_CLK,
   input wire logic             RST,
   input wire logic             CE,
   input wire logic             ERR_VALID,
   input wire logic             POP_REQ,
   input wire logic             POP_READY,
   input wire logic             RD_VALID,
   input wire logic             RD_READY,
   input wire logic             CLS_CMD,
   input wire logic             VIEW_ACTIVE,
   input wire logic             VIEW_EXIT,
   input wire logic             DISP_ON,
   input wire logic [ANN_W-1:0] ANN_OUT,
   input wire logic             TST_REQ,
   input wire logic             TST_BUSY,
   input wire logic             TST_DONE,
   input wire logic             FAULT_LED,
   input wire logic             BEEP,
   input wire logic             OVERFLOW,
   input wire logic [PTR_W-1:0] ERR_COUNT
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TST_D = int'(TST_RUN_CYC) + 1;
   logic quiet;

   // No flush and no pop in this cycle, so the queue only sees the new error.
   assign quiet = !CLS_CMD && !VIEW_EXIT && !VIEW_ACTIVE && !(POP_REQ && POP_READY);

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   beep_on_err_a: assert property (CE && ERR_VALID |=> BEEP)
      else $error("beep missing after an error");
   beep_idle_a: assert property (CE && !ERR_VALID |=> !BEEP)
      else $error("beep without an error");
   count_cap_a: assert property (ERR_COUNT <= DEPTH_CNT)
      else $error("queue count above its depth");
   fault_lit_a: assert property (ERR_COUNT != 5'h00 |-> FAULT_LED)
      else $error("fault indicator dark with records pending");
   clear_flush_a: assert property (CLS_CMD && !ERR_VALID |=> ERR_COUNT == 5'h00 && !OVERFLOW)
      else $error("clear command left records behind");
   ovf_mark_a: assert property (quiet && ERR_VALID && !OVERFLOW && ERR_COUNT == DEPTH_CNT
                                |=> OVERFLOW && ERR_COUNT == DEPTH_CNT)
      else $error("overflow not marked on a full queue");
   ovf_drop_a: assert property (quiet && ERR_VALID && OVERFLOW |=> OVERFLOW && $stable(ERR_COUNT))
      else $error("error stored while in overflow");
   empty_pop_a: assert property (ERR_COUNT == 5'h00 && POP_REQ && POP_READY && !ERR_VALID && !OVERFLOW
                                 |=> ERR_COUNT == 5'h00 && !OVERFLOW)
      else $error("pop on empty queue changed state");
   pop_answer_a: assert property (POP_REQ && POP_READY && !RD_VALID |=> RD_VALID)
      else $error("no answer one cycle after a query");
   ann_dark_a: assert property (!DISP_ON |=> ANN_OUT == 8'h00)
      else $error("annunciator lit with display off");
   tst_done_a: assert property (TST_REQ && !TST_BUSY && !TST_DONE |-> ##TST_D TST_DONE)
      else $error("self-test result not on time");

   cover property (ERR_VALID && OVERFLOW);
   cover property (TST_DONE);
   cover property (RD_VALID && RD_READY && ERR_COUNT == 5'h00);
endmodule

bind eqs_top eqs_properties #(.TST_RUN_CYC(TST_RUN_CYC)) eqs_properties_inst (.*);

// [dv/eqs_top_tb.sv]
// Self-checking bench for the error queue top module.
module eqs_top_tb;
   import eqs_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TST_RUN = 20;
   logic REF_CLK = 0, RST = 1, CE = 1, ERR_VALID = 0, POP_REQ, POP_READY, RD_VALID, RD_READY;
   logic CLS_CMD = 0, VIEW_ACTIVE = 0, VIEW_KEY = 0, VIEW_EXIT = 0, VIEW_VALID, VIEW_NOERR;
   logic POST_DONE = 0, POST_FAIL = 0, TST_REQ = 0, TST_FAIL_IN = 0, TST_DONE, TST_RESULT, TST_BUSY;
   logic DISP_ON = 1, FAULT_LED, BEEP, OVERFLOW, go = 0, stall = 0;
   logic [CODE_W-1:0] ERR_CODE = 16'h0000, RD_CODE, VIEW_CODE;
   logic [ID_W-1:0]   ERR_MSG_ID = 8'h07, RD_MSG_ID, VIEW_MSG_ID;
   logic [LEN_W-1:0]  ERR_MSG_LEN = 7'h05, RD_MSG_LEN;
   logic [PTR_W-1:0]  VIEW_SEL = 5'h00, ERR_COUNT;
   logic [ANN_W-1:0]  ANN_IN = 8'h00, ANN_OUT;
   logic [REC_W-1:0]  rec_q[$];
   int failures = 0, checks = 0;

   always #2.5 REF_CLK = ~REF_CLK;

   eqs_top #(.VIEW_TO_CYC(50), .TST_RUN_CYC(TST_RUN)) eqs_top_inst (.*);
   eqs_host_model eqs_host_model_inst (.clk(REF_CLK), .rst(RST), .go(go), .stall(stall),
      .pop_ready(POP_READY), .pop_req(POP_REQ), .rd_ready(RD_READY));

   always @(posedge REF_CLK) if (RD_VALID === 1'b1 && RD_READY === 1'b1)
      rec_q.push_back({RD_CODE, RD_MSG_ID, RD_MSG_LEN});

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic step(input int n = 1);
      repeat (n) begin
         @(posedge REF_CLK);
         #1;
      end
   endtask

   task automatic push(input logic [15:0] code, input logic [6:0] len);
      ERR_VALID = 1;
      ERR_CODE = code;
      ERR_MSG_LEN = len;
      step;
      ERR_VALID = 0;
      chk("beep on", 1, BEEP);
      step;
      chk("beep off", 0, BEEP);
   endtask

   // Each wait is bounded; running out counts a mismatch and ends the run.
   task automatic pop_n(input int n);
      int k;
      repeat (n) begin
         go = 1;
         step;
         go = 0;
         for (k = 0; k < 60 && POP_REQ !== 1'b0; k++) step;
         if (k == 60) begin chk("query taken", 1, 0); final_report; end
      end
   endtask

   task automatic wait_recs(input int n);
      int k;
      for (k = 0; k < 60 && rec_q.size() < n; k++) step;
      if (k == 60) begin chk("records seen", n, rec_q.size()); final_report; end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      RST = 1;
      step(8);
      RST = 0;
      chk("count", 0, ERR_COUNT);
      chk("no errors view", 1, VIEW_NOERR);
      chk("pop ready", 1, POP_READY);
      chk("fault", 0, FAULT_LED);
   endtask

   task automatic t_empty;
      rec_q.delete();
      pop_n(1);
      wait_recs(1);
      chk("empty record", {CODE_NOERR, MSG_NOERR, LEN_NOERR}, rec_q[0]);
      chk("count", 0, ERR_COUNT);
      chk("overflow", 0, OVERFLOW);
   endtask

   // The reader stalls so the two-entry buffer fills after two queries and POP_READY drops.
   task automatic t_order;
      rec_q.delete();
      push(16'h0011, 7'h05);
      push(16'hff9a, 7'h7f);
      push(16'h0033, 7'h05);
      chk("count", 3, ERR_COUNT);
      chk("fault", 1, FAULT_LED);
      VIEW_SEL = 5'h01;
      step;
      chk("view valid", 1, VIEW_VALID);
      chk("view code", 16'hff9a, VIEW_CODE);
      chk("view id", 8'h07, VIEW_MSG_ID);
      stall = 1;
      pop_n(2);
      step;
      chk("pop ready full", 0, POP_READY);
      stall = 0;
      pop_n(1);
      wait_recs(3);
      chk("first", {16'h0011, 8'h07, 7'h05}, rec_q[0]);
      chk("second", {16'hff9a, 8'h07, MSG_MAX_LEN}, rec_q[1]);
      chk("third", {16'h0033, 8'h07, 7'h05}, rec_q[2]);
      chk("count", 0, ERR_COUNT);
      chk("fault", 0, FAULT_LED);
   endtask

   task automatic t_overflow;
      rec_q.delete();
      ERR_VALID = 1;
      for (int i = 1; i <= 21; i++) begin
         ERR_CODE = i[15:0];
         step;
      end
      ERR_VALID = 0;
      step;
      chk("count", 20, ERR_COUNT);
      chk("overflow", 1, OVERFLOW);
      push(16'h0099, 7'h05);
      chk("count dropped", 20, ERR_COUNT);
      pop_n(20);
      wait_recs(20);
      for (int i = 1; i <= 19; i++) chk("record", {i[15:0], 8'h07, 7'h05}, rec_q[i-1]);
      chk("overflow record", {CODE_OVF, MSG_OVF, LEN_OVF}, rec_q[19]);
      chk("overflow cleared", 0, OVERFLOW);
   endtask

   task automatic t_flush;
      int k;
      push(16'h0001, 7'h05);
      push(16'h0002, 7'h05);
      CLS_CMD = 1;
      step;
      CLS_CMD = 0;
      chk("count clear", 0, ERR_COUNT);
      step;
      chk("no errors view", 1, VIEW_NOERR);
      push(16'h0003, 7'h05);
      VIEW_ACTIVE = 1;
      VIEW_EXIT = 1;
      step;
      VIEW_EXIT = 0;
      VIEW_ACTIVE = 0;
      chk("count exit", 0, ERR_COUNT);
      push(16'h0004, 7'h05);
      VIEW_ACTIVE = 1;
      step(45);
      chk("count before timeout", 1, ERR_COUNT);
      for (k = 0; k < 20 && ERR_COUNT !== 5'h00; k++) step;
      chk("count timeout", 0, ERR_COUNT);
      chk("timeout cycle", 5, k);
      if (k == 20) final_report;
      VIEW_ACTIVE = 0;
   endtask

   task automatic t_display;
      DISP_ON = 0;
      ANN_IN = 8'h5a;
      push(16'h0005, 7'h05);
      chk("annunciators off", 8'h00, ANN_OUT);
      chk("fault kept", 1, FAULT_LED);
      DISP_ON = 1;
      step(2);
      chk("annunciators on", 8'h5a, ANN_OUT);
      CLS_CMD = 1;
      step;
      CLS_CMD = 0;
      chk("fault", 0, FAULT_LED);
   endtask

   task automatic t_selftest(input logic fail);
      int n;
      TST_FAIL_IN = fail;
      TST_REQ = 1;
      step;
      TST_REQ = 0;
      for (n = 0; n < 60 && TST_DONE !== 1'b1; n++) step;
      chk("test time", TST_RUN, n);
      if (n == 60) final_report;
      chk("test result", fail, TST_RESULT);
      step;
      chk("test done pulse", 0, TST_DONE);
      chk("test fault", fail, FAULT_LED);
   endtask

   task automatic t_post;
      t_reset;
      POST_DONE = 1;
      POST_FAIL = 1;
      step;
      POST_DONE = 0;
      POST_FAIL = 0;
      step;
      chk("power-on fault", 1, FAULT_LED);
   endtask

   initial begin
      t_reset;
      t_empty;
      t_order;
      t_overflow;
      t_flush;
      t_display;
      t_selftest(1'b0);
      t_selftest(1'b1);
      t_post;
      final_report;
   end
endmodule

// [logic/eqs_skid.sv]
// Two-entry elastic buffer between the queue head and the remote reader.
module eqs_skid
   import eqs_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [REC_W-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [REC_W-1:0]      out_data
);

   logic [1:0]       cnt_reg;
   logic [1:0]       cnt_next;
   logic [REC_W-1:0] ent1_reg;
   logic             take_in;
   logic             take_out;

   assign take_in  = in_valid & in_ready;
   assign take_out = out_valid & out_ready;

   always_comb begin
      cnt_next = cnt_reg;
      if (take_in && !take_out) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (take_out && !take_in) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   // Ready and valid are kept as flops so the top sees registered handshakes.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg   <= 2'h0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else if (ce) begin
         cnt_reg   <= cnt_next;
         in_ready  <= (cnt_next != 2'h2);
         out_valid <= (cnt_next != 2'h0);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_data <= '0;
         ent1_reg <= '0;
      end else if (ce) begin
         if (take_out) begin
            if (cnt_reg == 2'h2) begin
               out_data <= ent1_reg;
               if (take_in) begin
                  ent1_reg <= in_data;
               end
            end else if (take_in) begin
               out_data <= in_data;
            end
         end else if (take_in) begin
            if (cnt_reg == 2'h0) begin
               out_data <= in_data;
            end else begin
               ent1_reg <= in_data;
            end
         end
      end
   end

endmodule

// [logic/eqs_top.sv]
// Error queue with fault indicator, beeper, self-test reporting and flush control.
//
// Behaviour
// RULE1 - The queue holds at most twenty error records.
// RULE2 - Records leave in arrival order, oldest first.
// RULE3 - Every remote read removes the record it returns.
// RULE4 - Fault indicator lit while records are pending, dark after the last read.
// RULE5 - One beeper pulse for each new error generated.
// RULE6 - An error arriving on a full queue overwrites the newest slot with -350.
// RULE7 - After overflow further errors are dropped until a record is removed.
// RULE8 - Reading an empty queue returns +0 no-error; panel view shows no errors.
// RULE9 - Queue is emptied at power-up and by the clear-status command.
// RULE10 - The device reset command leaves the queue contents untouched.
// RULE11 - A record is signed code plus message of at most 80 characters.
// RULE12 - Leaving the panel view or a 30 second view timeout flushes the queue.
// RULE13 - A failed power-on self-test lights the fault indicator.
// RULE14 - Complete self-test answers 0 on pass, 1 on fail, after 2 seconds.
// RULE15 - With the display off only the fault indicator stays active.
// RULE16 - The host reads one error per query until the no-error code returns.
// RULE17 - A pop on an empty queue leaves pointers and overflow state unchanged.
module eqs_top
   import eqs_pkg::*;
#(
   parameter longint unsigned VIEW_TO_CYC = VIEW_TIMEOUT_CYC,
   parameter longint unsigned TST_RUN_CYC = TST_CYC
) (
   input  wire logic              REF_CLK,
   input  wire logic              RST,
   input  wire logic              CE,
   input  wire logic              ERR_VALID,
   input  wire logic [CODE_W-1:0] ERR_CODE,
   input  wire logic [ID_W-1:0]   ERR_MSG_ID,
   input  wire logic [LEN_W-1:0]  ERR_MSG_LEN,
   input  wire logic              POP_REQ,
   output logic                   POP_READY,
   output logic                   RD_VALID,
   input  wire logic              RD_READY,
   output logic [CODE_W-1:0]      RD_CODE,
   output logic [ID_W-1:0]        RD_MSG_ID,
   output logic [LEN_W-1:0]       RD_MSG_LEN,
   input  wire logic              CLS_CMD,
   input  wire logic              VIEW_ACTIVE,
   input  wire logic              VIEW_KEY,
   input  wire logic              VIEW_EXIT,
   input  wire logic [PTR_W-1:0]  VIEW_SEL,
   output logic                   VIEW_VALID,
   output logic                   VIEW_NOERR,
   output logic [CODE_W-1:0]      VIEW_CODE,
   output logic [ID_W-1:0]        VIEW_MSG_ID,
   input  wire logic              POST_DONE,
   input  wire logic              POST_FAIL,
   input  wire logic              TST_REQ,
   input  wire logic              TST_FAIL_IN,
   output logic                   TST_DONE,
   output logic                   TST_RESULT,
   output logic                   TST_BUSY,
   input  wire logic              DISP_ON,
   input  wire logic [ANN_W-1:0]  ANN_IN,
   output logic [ANN_W-1:0]       ANN_OUT,
   output logic                   FAULT_LED,
   output logic                   BEEP,
   output logic                   OVERFLOW,
   output logic [PTR_W-1:0]       ERR_COUNT
);

   // ----------------------------------------------------------------
   // Storage and queue state
   // ----------------------------------------------------------------
   logic [REC_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0] rd_reg;
   logic [PTR_W-1:0] wr_reg;
   logic [PTR_W-1:0] cnt_reg;
   logic             ovf_reg;
   logic [PTR_W-1:0] rd_next;
   logic [PTR_W-1:0] wr_next;
   logic [PTR_W-1:0] cnt_next;
   logic             ovf_next;

   logic             mem_we;
   logic [PTR_W-1:0] mem_idx;
   logic [REC_W-1:0] mem_rec;

   logic             pop_acc;
   logic             pop_take;
   logic             flush;
   logic             view_tmo;
   logic [REC_W-1:0] rd_rec;
   logic [REC_W-1:0] skid_out;
   logic             skid_in_ready;
   logic             skid_out_valid;

   logic [PTR_W-1:0] rd_base;
   logic [PTR_W-1:0] wr_base;
   logic [PTR_W-1:0] cnt_base;
   logic             ovf_base;
   logic [LEN_W-1:0] len_clamp;

   logic [TMR_W-1:0] view_tmr_reg;
   logic [TMR_W-1:0] tst_tmr_reg;
   eqs_tst_t         tst_state_reg;
   logic             post_fail_reg;
   logic             tst_fail_reg;
   logic [PTR_W:0]   view_sum;
   logic [PTR_W-1:0] view_idx;
   logic             tst_fin;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_LAST) ? '0 : p + 5'h01;
   endfunction

   function automatic logic [PTR_W-1:0] ptr_dec(input logic [PTR_W-1:0] p);
      ptr_dec = (p == '0) ? PTR_LAST : p - 5'h01;
   endfunction

   // ----------------------------------------------------------------
   // Pop and flush decode
   // ----------------------------------------------------------------
   // A pop is taken only while the read buffer has room; otherwise the host
   // holds POP_REQ until POP_READY returns.
   assign pop_acc  = POP_REQ & POP_READY;
   assign pop_take = pop_acc & (cnt_reg != '0); // RULE3 RULE17

   // Only clear-status and the panel view empty the queue; a device reset
   // command is deliberately not an input of this block.
   assign flush = CLS_CMD | VIEW_EXIT | view_tmo; // RULE9 RULE10 RULE12

   assign rd_rec = mem[rd_reg]; // RULE2

   // Messages longer than the display buffer are cut rather than refused.
   assign len_clamp = (ERR_MSG_LEN > MSG_MAX_LEN) ? MSG_MAX_LEN : ERR_MSG_LEN; // RULE11

   // ----------------------------------------------------------------
   // Queue next state
   // ----------------------------------------------------------------
   // Removal and flush are applied first, then the arriving error is placed
   // against what is left, so an error in the cycle of a clear is kept.
   always_comb begin
      rd_base  = rd_reg;
      wr_base  = wr_reg;
      cnt_base = cnt_reg;
      ovf_base = ovf_reg;
      if (pop_take) begin
         rd_base  = ptr_inc(rd_reg); // RULE2 RULE3
         cnt_base = cnt_reg - 5'h01;
         ovf_base = 1'b0; // RULE7
      end
      if (flush) begin
         rd_base  = '0;
         wr_base  = '0;
         cnt_base = '0;
         ovf_base = 1'b0;
      end
   end

   always_comb begin
      rd_next  = rd_base;
      wr_next  = wr_base;
      cnt_next = cnt_base;
      ovf_next = ovf_base;
      mem_we   = 1'b0;
      mem_idx  = wr_base;
      mem_rec  = {ERR_CODE, ERR_MSG_ID, len_clamp}; // RULE11
      if (ERR_VALID && !ovf_base) begin // RULE7
         if (cnt_base < DEPTH_CNT) begin // RULE1
            mem_we   = 1'b1;
            wr_next  = ptr_inc(wr_base);
            cnt_next = cnt_base + 5'h01;
         end else begin
            mem_we   = 1'b1;
            mem_idx  = ptr_dec(wr_base); // RULE6
            mem_rec  = {CODE_OVF, MSG_OVF, LEN_OVF}; // RULE6
            ovf_next = 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rd_reg  <= '0; // RULE9
         wr_reg  <= '0;
         cnt_reg <= '0;
         ovf_reg <= 1'b0;
      end else if (CE) begin
         rd_reg  <= rd_next;
         wr_reg  <= wr_next;
         cnt_reg <= cnt_next;
         ovf_reg <= ovf_next;
      end
   end

   // Record contents need no reset; the counters decide what is valid.
   always_ff @(posedge REF_CLK) begin
      if (CE && mem_we) begin
         mem[mem_idx] <= mem_rec;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         OVERFLOW  <= 1'b0;
         ERR_COUNT <= '0;
      end else if (CE) begin
         OVERFLOW  <= ovf_next;
         ERR_COUNT <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Remote read path
   // ----------------------------------------------------------------
   // An empty queue answers with the no-error record, which is what lets the
   // host stop its drain loop.
   eqs_skid u_skid (
      .clk       (REF_CLK),
      .rst       (RST),
      .ce        (CE),
      .in_valid  (pop_acc),
      .in_ready  (skid_in_ready),
      .in_data   ((cnt_reg != '0) ? rd_rec : {CODE_NOERR, MSG_NOERR, LEN_NOERR}), // RULE8 RULE16
      .out_valid (skid_out_valid),
      .out_ready (RD_READY),
      .out_data  (skid_out)
   );

   assign POP_READY  = skid_in_ready;
   assign RD_VALID   = skid_out_valid;
   assign RD_CODE    = skid_out[REC_CODE_LSB +: CODE_W];
   assign RD_MSG_ID  = skid_out[REC_ID_LSB +: ID_W];
   assign RD_MSG_LEN = skid_out[REC_LEN_LSB +: LEN_W];

   // ----------------------------------------------------------------
   // Front-panel view
   // ----------------------------------------------------------------
   // The timer restarts on every key press and stands at zero outside the view.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         view_tmr_reg <= '0;
      end else if (CE) begin
         if (!VIEW_ACTIVE || VIEW_KEY || view_tmo) begin
            view_tmr_reg <= '0;
         end else begin
            view_tmr_reg <= view_tmr_reg + 33'h000000001;
         end
      end
   end

   assign view_tmo = VIEW_ACTIVE && !VIEW_KEY &&
                     (view_tmr_reg == TMR_W'(VIEW_TO_CYC - 1)); // RULE12

   // Entry VIEW_SEL counts from the oldest record.
   assign view_sum = {1'b0, rd_reg} + {1'b0, VIEW_SEL};
   assign view_idx = (view_sum >= {1'b0, DEPTH_CNT}) ?
                     PTR_W'(view_sum - {1'b0, DEPTH_CNT}) : view_sum[PTR_W-1:0];

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         VIEW_VALID  <= 1'b0;
         VIEW_NOERR  <= 1'b1;
         VIEW_CODE   <= CODE_NOERR;
         VIEW_MSG_ID <= MSG_NOERR;
      end else if (CE) begin
         VIEW_VALID  <= (VIEW_SEL < cnt_reg);
         VIEW_NOERR  <= (cnt_reg == '0); // RULE8
         VIEW_CODE   <= mem[view_idx][REC_CODE_LSB +: CODE_W];
         VIEW_MSG_ID <= mem[view_idx][REC_ID_LSB +: ID_W];
      end
   end

   // ----------------------------------------------------------------
   // Self-test
   // ----------------------------------------------------------------
   // The power-on result latches until the next reset; the fault stays lit
   // even if the queue is drained, since the unit is not trustworthy.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         post_fail_reg <= 1'b0;
      end else if (CE && POST_DONE && POST_FAIL) begin
         post_fail_reg <= 1'b1; // RULE13
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tst_state_reg <= EQS_TST_IDLE;
         tst_tmr_reg   <= '0;
      end else if (CE) begin
         unique case (tst_state_reg)
            EQS_TST_IDLE: begin
               tst_tmr_reg <= '0;
               if (TST_REQ) begin
                  tst_state_reg <= EQS_TST_RUN;
               end
            end
            EQS_TST_RUN: begin
               if (tst_tmr_reg == TMR_W'(TST_RUN_CYC - 1)) begin // RULE14
                  tst_state_reg <= EQS_TST_IDLE;
                  tst_tmr_reg   <= '0;
               end else begin
                  tst_tmr_reg <= tst_tmr_reg + 33'h000000001;
               end
            end
         endcase
      end
   end

   assign tst_fin = (tst_state_reg == EQS_TST_RUN) && (tst_tmr_reg == TMR_W'(TST_RUN_CYC - 1));

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         TST_DONE     <= 1'b0;
         TST_RESULT   <= TST_PASS;
         TST_BUSY     <= 1'b0;
         tst_fail_reg <= 1'b0;
      end else if (CE) begin
         TST_DONE <= tst_fin;
         TST_BUSY <= (tst_state_reg == EQS_TST_RUN) && !tst_fin;
         if (tst_fin) begin
            TST_RESULT <= TST_FAIL_IN ? TST_FAIL : TST_PASS; // RULE14
            if (TST_FAIL_IN) begin
               tst_fail_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Indicators and beeper
   // ----------------------------------------------------------------
   // The beep follows every generated error, stored or dropped, so an
   // operator still hears errors lost to overflow.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         BEEP      <= 1'b0;
         FAULT_LED <= 1'b0;
         ANN_OUT   <= '0;
      end else if (CE) begin
         BEEP      <= ERR_VALID; // RULE5
         FAULT_LED <= (cnt_next != '0) || post_fail_reg || tst_fail_reg; // RULE4 RULE13 RULE15
         ANN_OUT   <= DISP_ON ? ANN_IN : '0; // RULE15
      end
   end

endmodule
